/* dtf_defines.vh */
// constants for the serial line framer: register map, fields, codes, timing
// assumes a 100 MHz core clock and a 44.736 Mbit/s line
`ifndef DTF_DEFINES_VH
`define DTF_DEFINES_VH
// register byte offsets
`define DTF_REG_CTRL 12'h000
`define DTF_REG_PAT 12'h004
`define DTF_REG_UWORD 12'h008
`define DTF_REG_ALARM 12'h00C
`define DTF_REG_STAT 12'h010
`define DTF_REG_TRIM 12'h014
`define DTF_MEM_PAGE 4'h8
// read masks and reset values
`define DTF_CTRL_MASK 32'h000000EF
`define DTF_PAT_MASK 32'h07FF01FF
`define DTF_ALARM_MASK 32'h00003F0F
`define DTF_CTRL_RST 32'h00000002
`define DTF_PAT_RST 32'h001F0173
// control fields
`define DTF_C_ON 0
`define DTF_C_FRM 1
`define DTF_C_CBIT 2
`define DTF_C_INV 3
`define DTF_C_PRESET 4
`define DTF_C_RXF 5
`define DTF_SRC_INT 2'h0
`define DTF_SRC_EXT 2'h1
`define DTF_SRC_RCV 2'h2
// pattern modes
`define DTF_PM_OFF 4'h0
`define DTF_PM_USER32 4'h1
`define DTF_PM_USER2K 4'h2
`define DTF_PM_PRBS 4'h3
`define DTF_PM_QRSS 4'h4
`define DTF_PM_FOX 4'h5
`define DTF_PM_ZERO 4'h6
`define DTF_PM_ONE 4'h7
`define DTF_PM_ALT11 4'h8
`define DTF_PM_ALT13 4'h9
`define DTF_PM_ALT17 4'hA
`define DTF_PM_ALT324 4'hB
`define DTF_PRESET_ORDER 5'h17
`define DTF_QRSS_MAX 4'hE
// alarm and control code words
`define DTF_HI_EQUIP_FAIL_SA_CODE 6'h19
`define DTF_HI_LOS_CODE 6'h0E
`define DTF_HI_OUT_OF_FRAME_CODE 6'h00
`define DTF_HI_AIS_CODE 6'h16
`define DTF_HI_IDLE_CODE 6'h1A
`define DTF_HI_EQUIP_FAIL_NSA_CODE 6'h0F
`define DTF_HI_COMMON_EQUIP_FAIL_CODE 6'h1D
`define DTF_MULTI_LOW_LOS_CODE 6'h15
`define DTF_LOW_LOS_CODE 6'h1E
`define DTF_LOW_EQUIP_FAIL_CODE 6'h05
`define DTF_LINE_LOOP_ON_CODE 6'h07
`define DTF_LINE_LOOP_OFF_CODE 6'h1C
`define DTF_ASEL_OFF 4'h0
`define DTF_ASEL_USER 4'hE
// frame shape
`define DTF_BLK_LAST 7'h54
`define DTF_BLK_END 3'h7
`define DTF_ROW_END 3'h6
// timing
`define DTF_CORE_HZ 64'd100000000
`define DTF_LINE_HZ 64'd44736000
`define DTF_CLK_PERIOD_NS 10
`define DTF_CLK_LOSS_NS 1000
`define DTF_CLK_LOSS_CYC 12'h064
`endif

/* dtf_pattern.v */
// payload test pattern source: prbs, qrss, fixed, alternating, user words
// assumes adv is a one-cycle pulse from the framer on the same clock
`timescale 1ns/1ps
`default_nettype none
`include "dtf_defines.vh"
module dtf_pattern (
	// clock and reset
	input wire clk,
	input wire rst,
	// control
	input wire adv,
	input wire [3:0] mode,
	input wire [4:0] order,
	input wire inv,
	input wire [31:0] uword,
	input wire [10:0] ulen,
	// user pattern memory write
	input wire mwe,
	input wire [5:0] maddr,
	input wire [31:0] mdata,
	// current bit
	output wire bitout
);
	reg [31:0] mem [0:63];
	reg [30:0] lfsr;
	reg [10:0] idx;
	reg [3:0] zrun;
	reg [30:0] taps;
	reg [31:0] word;
	reg [10:0] lenm1;
	reg raw;
	wire fb;
	wire wbit;

	always @(posedge clk) begin
		if (mwe)
			mem[maddr] <= mdata;
	end

	// feedback taps per order, unknown orders fall back to 23
	always @* begin
		if (mode == `DTF_PM_QRSS)
			taps = 31'h00090000;
		else case (order)
			5'h09: taps = 31'h00000110;
			5'h0B: taps = 31'h00000500;
			5'h0F: taps = 31'h00006000;
			5'h14: taps = 31'h00080004;
			5'h1D: taps = 31'h14000000;
			5'h1F: taps = 31'h48000000;
			default: taps = 31'h00420000;
		endcase
	end
	assign fb = ^(lfsr & taps);

	// cyclic word sources and their lengths minus one
	always @* begin
		word = uword;
		lenm1 = {6'h00, ulen[4:0]};
		case (mode)
			`DTF_PM_USER2K: lenm1 = ulen;
			`DTF_PM_FOX: begin
				word = 32'h464F5820;
				lenm1 = 11'h01F;
			end
			`DTF_PM_ALT11: begin
				word = 32'h80000000;
				lenm1 = 11'h001;
			end
			`DTF_PM_ALT13: begin
				word = 32'h80000000;
				lenm1 = 11'h003;
			end
			`DTF_PM_ALT17: begin
				word = 32'h80000000;
				lenm1 = 11'h007;
			end
			`DTF_PM_ALT324: begin
				word = 32'h80808000;
				lenm1 = 11'h017;
			end
			default: ;
		endcase
	end
	assign wbit = (mode == `DTF_PM_USER2K) ? mem[idx[10:5]][~idx[4:0]] : word[~idx[4:0]];

	always @* begin
		case (mode)
			`DTF_PM_PRBS: raw = fb;
			`DTF_PM_QRSS: raw = fb | (zrun >= `DTF_QRSS_MAX);
			`DTF_PM_ZERO: raw = 1'b0;
			`DTF_PM_ONE: raw = 1'b1;
			default: raw = wbit;
		endcase
	end
	assign bitout = (mode == `DTF_PM_OFF) ? 1'b0 : (raw ^ inv);

	always @(posedge clk or posedge rst) begin
		if (rst) begin
			lfsr <= 31'h7FFFFFFF;
			idx <= 11'h000;
			zrun <= 4'h0;
		end else if (adv) begin
			lfsr <= (lfsr == 31'h00000000) ? 31'h7FFFFFFF : {lfsr[29:0], fb};
			idx <= (idx >= lenm1) ? 11'h000 : idx + 11'h001;
			zrun <= raw ? 4'h0 : ((zrun == 4'hF) ? zrun : zrun + 4'h1);
		end
	end
endmodule // dtf_pattern
`default_nettype wire

/* dtf_framer.v */
// serial line transmit framer with test pattern source and axi4-lite registers
// assumes ext and recovered clocks arrive asynchronous on plain input pins
// Behaviour
// - frame is 56 overhead bits and 4704 payload bits, about 9398.3 Hz
// - line rate 44.736 Mbit/s nominal, trimmable by +/-125 ppm
// - overhead assignment selectable between M13 and C-bit
// - seven rows of eight overhead bits, column one X X P P M0 M1 M0
// - rows five to seven of column one carry 0, 1, 0
// - rows one and two carry receive failure, rows three and four even parity
// - C-bit row one AIC, NA, alarm bit; row five DL; others user link; the code sends fixed ones in the DL and user link rows
// - C-bit row three carries C-bit parity, row four block error bits; the code sends fixed ones in row four
// - alarm code only sent in C-bit mode; off sends none
// - equip fail 011001, loss of signal 001110, out of frame 000000
// - AIS received 010110, idle received 011010
// - equip fail non-affecting 001111, common equip fail 011101
// - multiple low LOS 010101, single 011110, low equip fail 000101
// - line loopback on 000111, off 011100
// - user choice sends configurable six-bit code
// - patterns off, user, PRBS, QRSS, fox, zeros, ones, alternating
// - pattern may be sent normal or inverted
// - preset selects inverted PRBS order 23
// - user pattern length 1..32 or 1..2048 bits, repeating
// - framing insertion can be switched off
// - clock from internal, external or recovered source, with detect flag
// - off mode disables the transmitter
//
// Implementation choices: the register offsets and the AXI4-Lite slave port.
`timescale 1ns/1ps
`default_nettype none
`include "dtf_defines.vh"
module dtf_framer (
	// clock and reset
	input wire CORE_CLK,
	input wire RST,
	// axi4-lite write address
	input wire [11:0] S_AXI_AWADDR,
	input wire S_AXI_AWVALID,
	output reg S_AXI_AWREADY,
	// axi4-lite write data
	input wire [31:0] S_AXI_WDATA,
	input wire [3:0] S_AXI_WSTRB,
	input wire S_AXI_WVALID,
	output reg S_AXI_WREADY,
	// axi4-lite write response
	output reg [1:0] S_AXI_BRESP,
	output reg S_AXI_BVALID,
	input wire S_AXI_BREADY,
	// axi4-lite read
	input wire [11:0] S_AXI_ARADDR,
	input wire S_AXI_ARVALID,
	output reg S_AXI_ARREADY,
	output reg [31:0] S_AXI_RDATA,
	output reg [1:0] S_AXI_RRESP,
	output reg S_AXI_RVALID,
	input wire S_AXI_RREADY,
	// clock source pins
	input wire EXT_CLK_IN,
	input wire RCV_CLK_IN,
	// line side
	output reg TX_DATA,
	output reg TX_BIT_STB,
	output reg TX_FRAME_START,
	output reg TX_ENABLE,
	output reg CLK_DETECT
);
	localparam [63:0] NCO_WIDE = (`DTF_LINE_HZ << 32) / `DTF_CORE_HZ;
	localparam [11:0] LOSS_CYC = `DTF_CLK_LOSS_CYC;

	reg [31:0] ctrl;
	reg [31:0] pat;
	reg [31:0] uword;
	reg [31:0] alarm;
	reg [31:0] trim;
	reg [11:0] aw_addr;
	reg aw_full;
	reg [31:0] w_data;
	reg [3:0] w_strb;
	reg w_full;
	reg [31:0] rd;
	reg rok;
	reg wok;
	wire wr_do;
	wire [11:0] wa;
	wire mem_we;

	// byte lane merge for partial writes
	function [31:0] merge;
		input [31:0] o;
		input [31:0] n;
		input [3:0] s;
		integer i;
		begin
			for (i = 0; i < 4; i = i + 1)
				merge[i*8 +: 8] = s[i] ? n[i*8 +: 8] : o[i*8 +: 8];
		end
	endfunction

	// axi write channels, taken in either order
	assign wr_do = aw_full & w_full & ~S_AXI_BVALID;
	assign wa = {aw_addr[11:2], 2'b00};
	assign mem_we = wr_do & (wa[11:8] == `DTF_MEM_PAGE) & (w_strb == 4'hF);

	always @* begin
		case (wa)
			`DTF_REG_CTRL, `DTF_REG_PAT, `DTF_REG_UWORD: wok = 1'b1;
			`DTF_REG_ALARM, `DTF_REG_STAT, `DTF_REG_TRIM: wok = 1'b1;
			default: wok = (wa[11:8] == `DTF_MEM_PAGE);
		endcase
	end

	always @(posedge CORE_CLK or posedge RST) begin
		if (RST) begin
			S_AXI_AWREADY <= 1'b1;
			S_AXI_WREADY <= 1'b1;
			S_AXI_BVALID <= 1'b0;
			S_AXI_BRESP <= 2'h0;
			aw_full <= 1'b0;
			w_full <= 1'b0;
			aw_addr <= 12'h000;
			w_data <= 32'h00000000;
			w_strb <= 4'h0;
		end else begin
			if (S_AXI_AWVALID & S_AXI_AWREADY) begin
				aw_addr <= S_AXI_AWADDR;
				aw_full <= 1'b1;
				S_AXI_AWREADY <= 1'b0;
			end
			if (S_AXI_WVALID & S_AXI_WREADY) begin
				w_data <= S_AXI_WDATA;
				w_strb <= S_AXI_WSTRB;
				w_full <= 1'b1;
				S_AXI_WREADY <= 1'b0;
			end
			if (wr_do) begin
				aw_full <= 1'b0;
				w_full <= 1'b0;
				S_AXI_BVALID <= 1'b1;
				S_AXI_BRESP <= wok ? 2'h0 : 2'h2;
			end
			if (S_AXI_BVALID & S_AXI_BREADY) begin
				S_AXI_BVALID <= 1'b0;
				S_AXI_AWREADY <= 1'b1;
				S_AXI_WREADY <= 1'b1;
			end
		end
	end

	// register writes
	always @(posedge CORE_CLK or posedge RST) begin
		if (RST) begin
			ctrl <= `DTF_CTRL_RST;
			pat <= `DTF_PAT_RST;
			uword <= 32'h00000000;
			alarm <= 32'h00000000;
			trim <= 32'h00000000;
		end else if (wr_do) begin
			case (wa)
				`DTF_REG_CTRL: begin
					ctrl <= merge(ctrl, w_data, w_strb) & `DTF_CTRL_MASK;
					if (w_strb[0] & w_data[`DTF_C_PRESET]) begin
						ctrl[`DTF_C_INV] <= 1'b1;
						pat[3:0] <= `DTF_PM_PRBS;
						pat[8:4] <= `DTF_PRESET_ORDER;
					end
				end
				`DTF_REG_PAT: pat <= merge(pat, w_data, w_strb) & `DTF_PAT_MASK;
				`DTF_REG_UWORD: uword <= merge(uword, w_data, w_strb);
				`DTF_REG_ALARM: alarm <= merge(alarm, w_data, w_strb) & `DTF_ALARM_MASK;
				`DTF_REG_TRIM: trim <= merge(trim, w_data, w_strb);
				default: ;
			endcase
		end
	end

	// read channel
	reg [15:0] frame_cnt;

	always @* begin
		rd = 32'h00000000;
		rok = 1'b1;
		case ({S_AXI_ARADDR[11:2], 2'b00})
			`DTF_REG_CTRL: rd = ctrl;
			`DTF_REG_PAT: rd = pat;
			`DTF_REG_UWORD: rd = uword;
			`DTF_REG_ALARM: rd = alarm;
			`DTF_REG_STAT: rd = {frame_cnt, 14'h0000, TX_ENABLE, CLK_DETECT};
			`DTF_REG_TRIM: rd = trim;
			default: rok = (S_AXI_ARADDR[11:8] == `DTF_MEM_PAGE);
		endcase
	end

	always @(posedge CORE_CLK or posedge RST) begin
		if (RST) begin
			S_AXI_ARREADY <= 1'b1;
			S_AXI_RVALID <= 1'b0;
			S_AXI_RDATA <= 32'h00000000;
			S_AXI_RRESP <= 2'h0;
		end else begin
			if (S_AXI_ARVALID & S_AXI_ARREADY) begin
				S_AXI_ARREADY <= 1'b0;
				S_AXI_RVALID <= 1'b1;
				S_AXI_RDATA <= rd;
				S_AXI_RRESP <= rok ? 2'h0 : 2'h2;
			end
			if (S_AXI_RVALID & S_AXI_RREADY) begin
				S_AXI_RVALID <= 1'b0;
				S_AXI_ARREADY <= 1'b1;
			end
		end
	end

	// bit timing: nco or synchronised pin clock
	reg [2:0] ext_s;
	reg [2:0] rcv_s;
	reg [31:0] phase;
	reg [11:0] lcnt;
	reg stb;
	wire [1:0] src;
	wire ext_mode;
	wire sel_edge;
	wire [32:0] next_phase;
	wire on;

	assign on = ctrl[`DTF_C_ON];
	assign src = ctrl[7:6];
	assign ext_mode = (src == `DTF_SRC_EXT) | (src == `DTF_SRC_RCV);
	assign sel_edge = (src == `DTF_SRC_EXT) ? (ext_s[1] & ~ext_s[2]) :
		(src == `DTF_SRC_RCV) ? (rcv_s[1] & ~rcv_s[2]) : 1'b0;
	assign next_phase = {1'b0, phase} + {1'b0, NCO_WIDE[31:0] + trim};

	always @(posedge CORE_CLK or posedge RST) begin
		if (RST) begin
			ext_s <= 3'h0;
			rcv_s <= 3'h0;
			phase <= 32'h00000000;
			lcnt <= 12'h000;
			stb <= 1'b0;
			CLK_DETECT <= 1'b0;
		end else begin
			ext_s <= {ext_s[1:0], EXT_CLK_IN};
			rcv_s <= {rcv_s[1:0], RCV_CLK_IN};
			phase <= next_phase[31:0];
			stb <= ext_mode ? sel_edge : next_phase[32];
			if (sel_edge)
				lcnt <= 12'h000;
			else if (lcnt != LOSS_CYC)
				lcnt <= lcnt + 12'h001;
			CLK_DETECT <= ~ext_mode | (lcnt != LOSS_CYC);
		end
	end

	// frame position and overhead
	reg [6:0] bcnt;
	reg [2:0] blk;
	reg [2:0] row;
	reg [3:0] aidx;
	reg par_acc;
	reg par_prev;
	reg [5:0] acode;
	reg ohbit;
	wire cbit;
	wire oh;
	wire pbit;
	wire last;
	wire [15:0] aword;
	wire abit;
	wire adv;

	assign cbit = ctrl[`DTF_C_CBIT];
	assign oh = ctrl[`DTF_C_FRM] & (bcnt == 7'h00);
	assign last = (bcnt == `DTF_BLK_LAST) & (blk == `DTF_BLK_END) & (row == `DTF_ROW_END);
	assign adv = stb & on & ~oh;

	always @* begin
		case (alarm[3:0])
			4'h1: acode = `DTF_HI_EQUIP_FAIL_SA_CODE;
			4'h2: acode = `DTF_HI_LOS_CODE;
			4'h3: acode = `DTF_HI_OUT_OF_FRAME_CODE;
			4'h4: acode = `DTF_HI_AIS_CODE;
			4'h5: acode = `DTF_HI_IDLE_CODE;
			4'h6: acode = `DTF_HI_EQUIP_FAIL_NSA_CODE;
			4'h7: acode = `DTF_HI_COMMON_EQUIP_FAIL_CODE;
			4'h8: acode = `DTF_MULTI_LOW_LOS_CODE;
			4'h9: acode = `DTF_LOW_LOS_CODE;
			4'hA: acode = `DTF_LOW_EQUIP_FAIL_CODE;
			4'hB: acode = `DTF_LOW_EQUIP_FAIL_CODE;
			4'hC: acode = `DTF_LINE_LOOP_ON_CODE;
			4'hD: acode = `DTF_LINE_LOOP_OFF_CODE;
			`DTF_ASEL_USER: acode = alarm[13:8];
			default: acode = 6'h3F;
		endcase
	end

	// off or unknown selection leaves the channel all ones
	assign aword = ((alarm[3:0] == `DTF_ASEL_OFF) | (alarm[3:0] == 4'hF)) ? 16'hFFFF :
		{1'b0, acode, 1'b0, 8'hFF};
	assign abit = aword[~aidx];

	always @* begin
		case (blk)
			3'h0: begin
				if (row < 3'h2)
					ohbit = ~ctrl[`DTF_C_RXF];
				else if (row < 3'h4)
					ohbit = par_prev;
				else
					ohbit = (row == 3'h5);
			end
			3'h1, 3'h7: ohbit = 1'b1;
			3'h3, 3'h5: ohbit = 1'b0;
			default: begin
				if (~cbit)
					ohbit = 1'b0;
				else case (row)
					3'h0: ohbit = (blk == 3'h6) ? abit : 1'b1;
					3'h2: ohbit = par_prev;
					default: ohbit = 1'b1;
				endcase
			end
		endcase
	end

	dtf_pattern u_pat (
		.clk(CORE_CLK),
		.rst(RST),
		.adv(adv),
		.mode(pat[3:0]),
		.order(pat[8:4]),
		.inv(ctrl[`DTF_C_INV]),
		.uword(uword),
		.ulen(pat[26:16]),
		.mwe(mem_we),
		.maddr(aw_addr[7:2]),
		.mdata(w_data),
		.bitout(pbit)
	);

	always @(posedge CORE_CLK or posedge RST) begin
		if (RST) begin
			bcnt <= 7'h00;
			blk <= 3'h0;
			row <= 3'h0;
			aidx <= 4'h0;
			par_acc <= 1'b0;
			par_prev <= 1'b0;
			frame_cnt <= 16'h0000;
			TX_DATA <= 1'b0;
			TX_BIT_STB <= 1'b0;
			TX_FRAME_START <= 1'b0;
			TX_ENABLE <= 1'b0;
		end else if (~on) begin
			bcnt <= 7'h00;
			blk <= 3'h0;
			row <= 3'h0;
			aidx <= 4'h0;
			par_acc <= 1'b0;
			TX_DATA <= 1'b0;
			TX_BIT_STB <= 1'b0;
			TX_FRAME_START <= 1'b0;
			TX_ENABLE <= 1'b0;
		end else begin
			TX_ENABLE <= 1'b1;
			TX_BIT_STB <= stb;
			TX_FRAME_START <= stb & (bcnt == 7'h00) & (blk == 3'h0) & (row == 3'h0);
			if (stb) begin
				TX_DATA <= oh ? ohbit : pbit;
				if (bcnt == `DTF_BLK_LAST) begin
					bcnt <= 7'h00;
					blk <= blk + 3'h1;
					if (blk == `DTF_BLK_END)
						row <= (row == `DTF_ROW_END) ? 3'h0 : row + 3'h1;
				end else
					bcnt <= bcnt + 7'h01;
				if (last) begin
					par_prev <= par_acc ^ pbit;
					par_acc <= 1'b0;
					aidx <= aidx + 4'h1;
					frame_cnt <= frame_cnt + 16'h0001;
				end else if (~oh)
					par_acc <= par_acc ^ pbit;
			end
		end
	end
endmodule // dtf_framer
`default_nettype wire

/* dtf_framer_sva.sv */
// checker for the line framer: frame shape, overhead columns, bus holds
// assumes it is bound into dtf_framer and sees only its ports
`timescale 1ns/1ps
`default_nettype none
module dtf_chk (
	// clock and reset
	input wire CORE_CLK,
	input wire RST,
	// register bus
	input wire [11:0] S_AXI_AWADDR,
	input wire S_AXI_AWVALID,
	input wire S_AXI_AWREADY,
	input wire [31:0] S_AXI_WDATA,
	input wire [3:0] S_AXI_WSTRB,
	input wire S_AXI_WVALID,
	input wire S_AXI_WREADY,
	input wire [1:0] S_AXI_BRESP,
	input wire S_AXI_BVALID,
	input wire S_AXI_BREADY,
	input wire [31:0] S_AXI_RDATA,
	input wire S_AXI_RVALID,
	input wire S_AXI_RREADY,
	// line side
	input wire TX_DATA,
	input wire TX_BIT_STB,
	input wire TX_FRAME_START,
	input wire TX_ENABLE
);
	default clocking @(posedge CORE_CLK); endclocking
	default disable iff (RST);
	reg frm;
	reg seen;
	reg [12:0] idx;
	wire [12:0] cur = TX_FRAME_START ? 13'h0000 : idx;
	wire [12:0] blk = (cur / 13'd85) % 13'd8;
	wire [12:0] row = cur / 13'd680;
	wire oh = TX_BIT_STB && seen && frm && (cur % 13'd85 == 13'h0000);
	// framing switch copied from control writes, bit index within frame
	always @(posedge CORE_CLK or posedge RST) begin
		if (RST) begin
			frm <= 1'b1;
			seen <= 1'b0;
			idx <= 13'h0000;
		end else begin
			if (S_AXI_AWVALID && S_AXI_AWREADY && S_AXI_WVALID && S_AXI_WREADY
				&& S_AXI_AWADDR == 12'h000 && S_AXI_WSTRB[0])
				frm <= S_AXI_WDATA[1];
			if (!TX_ENABLE)
				seen <= 1'b0;
			else if (TX_FRAME_START)
				seen <= 1'b1;
			if (TX_BIT_STB)
				idx <= cur + 13'h0001;
		end
	end
	AST_FS_ON_STB: assert property (TX_FRAME_START |-> TX_BIT_STB && TX_ENABLE)
		else $error("frame start without line bit");
	AST_FRAME_LEN: assert property (TX_FRAME_START && seen |-> idx == 13'd4760)
		else $error("frame length wrong");
	AST_F1_BITS: assert property (oh && (blk == 13'd1 || blk == 13'd7) |-> TX_DATA)
		else $error("F1 bit wrong");
	AST_F0_BITS: assert property (oh && (blk == 13'd3 || blk == 13'd5) |-> !TX_DATA)
		else $error("F0 bit wrong");
	AST_M_BITS: assert property (oh && blk == 13'd0 && row >= 13'd4 |->
		TX_DATA == (row == 13'd5))
		else $error("alignment bit wrong");
	AST_OFF_QUIET: assert property (!TX_ENABLE && $past(!TX_ENABLE) |->
		!(TX_BIT_STB || TX_DATA || TX_FRAME_START))
		else $error("line active while off");
	AST_B_HOLD: assert property (S_AXI_BVALID && !S_AXI_BREADY |=>
		S_AXI_BVALID && $stable(S_AXI_BRESP))
		else $error("write response dropped");
	AST_R_HOLD: assert property (S_AXI_RVALID && !S_AXI_RREADY |=>
		S_AXI_RVALID && $stable(S_AXI_RDATA))
		else $error("read data dropped");
	AST_B_TIME: assert property (S_AXI_AWVALID && S_AXI_AWREADY && S_AXI_WVALID
		&& S_AXI_WREADY |-> ##[1:3] S_AXI_BVALID)
		else $error("write response late");
endmodule // dtf_chk
bind dtf_framer dtf_chk u_chk (.CORE_CLK(CORE_CLK), .RST(RST),
	.S_AXI_AWADDR(S_AXI_AWADDR), .S_AXI_AWVALID(S_AXI_AWVALID),
	.S_AXI_AWREADY(S_AXI_AWREADY), .S_AXI_WDATA(S_AXI_WDATA), .S_AXI_WSTRB(S_AXI_WSTRB),
	.S_AXI_WVALID(S_AXI_WVALID), .S_AXI_WREADY(S_AXI_WREADY), .S_AXI_BRESP(S_AXI_BRESP),
	.S_AXI_BVALID(S_AXI_BVALID), .S_AXI_BREADY(S_AXI_BREADY), .S_AXI_RDATA(S_AXI_RDATA),
	.S_AXI_RVALID(S_AXI_RVALID), .S_AXI_RREADY(S_AXI_RREADY), .TX_DATA(TX_DATA),
	.TX_BIT_STB(TX_BIT_STB), .TX_FRAME_START(TX_FRAME_START), .TX_ENABLE(TX_ENABLE));
`default_nettype wire

/* dtf_line_eq.sv */
// line equipment model: far-end timing sources for the framer clock pins
// assumes the bench switches each source; an idle source stands at 0
`timescale 1ns/1ps
`default_nettype none
module dtf_line_eq (
	// source controls
	input wire logic ext_on,
	input wire logic rcv_on,
	// timing pins
	output logic ext_clk,
	output logic rcv_clk
);
	initial begin
		ext_clk = 1'b0;
		rcv_clk = 1'b0;
		forever begin
			#11.176; // about 60 ppm fast
			ext_clk = ext_on ? !ext_clk : 1'b0;
			rcv_clk = rcv_on ? !rcv_clk : 1'b0;
		end
	end
endmodule // dtf_line_eq
`default_nettype wire

/* tb.sv */
// bench for the line framer: registers, line frames, clock sources
// assumes dtf_framer, its bound checker and the line equipment model
`timescale 1ns/1ps
`default_nettype none
module tb;
	logic core_clk = 1'b0;
	logic rst = 1'b1;
	logic [11:0] awaddr = 12'h000;
	logic [11:0] araddr = 12'h000;
	logic [31:0] wdata = 32'h00000000;
	logic awvalid = 1'b0;
	logic wvalid = 1'b0;
	logic bready = 1'b0;
	logic arvalid = 1'b0;
	logic rready = 1'b0;
	logic ext_on = 1'b0;
	logic rcv_on = 1'b0;
	wire awready, wready, bvalid, arready, rvalid, tx_data, tx_stb, tx_fs, tx_en, clk_det;
	wire ext_clk, rcv_clk;
	wire [1:0] bresp;
	wire [1:0] rresp;
	wire [31:0] rdata;
	integer num_errors = 0;
	integer n_compared = 0;
	integer seed = 49;
	integer f, w;
	logic [31:0] uw;
	logic [5:0] uc;
	logic [15:0] wd;
	logic [5:0] code [0:15];
	logic [1:0] bq [$];
	logic [33:0] rq [$];
	integer lq [$];
	dtf_framer u_dut (.CORE_CLK(core_clk), .RST(rst),
		.S_AXI_AWADDR(awaddr), .S_AXI_AWVALID(awvalid), .S_AXI_AWREADY(awready),
		.S_AXI_WDATA(wdata), .S_AXI_WSTRB(4'hF), .S_AXI_WVALID(wvalid),
		.S_AXI_WREADY(wready), .S_AXI_BRESP(bresp), .S_AXI_BVALID(bvalid),
		.S_AXI_BREADY(bready), .S_AXI_ARADDR(araddr), .S_AXI_ARVALID(arvalid),
		.S_AXI_ARREADY(arready), .S_AXI_RDATA(rdata), .S_AXI_RRESP(rresp),
		.S_AXI_RVALID(rvalid), .S_AXI_RREADY(rready), .EXT_CLK_IN(ext_clk),
		.RCV_CLK_IN(rcv_clk), .TX_DATA(tx_data), .TX_BIT_STB(tx_stb),
		.TX_FRAME_START(tx_fs), .TX_ENABLE(tx_en), .CLK_DETECT(clk_det));
	dtf_line_eq u_line (.ext_on(ext_on), .rcv_on(rcv_on), .ext_clk(ext_clk),
		.rcv_clk(rcv_clk));
	initial begin
		forever #5 core_clk = !core_clk;
	end
	task chk(input string nm, input logic [33:0] e, input logic [33:0] g);
		n_compared = n_compared + 1;
		if (g !== e) begin
			num_errors = num_errors + 1;
			$display("wrong value %s expected %h seen %h", nm, e, g);
		end
	endtask
	task end_of_test;
		$display("compared %0d errors %0d", n_compared, num_errors);
		if (num_errors == 0 && n_compared > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask
	task hang;
		num_errors = num_errors + 1;
		$display("wrong value wait expected done seen timeout");
		end_of_test;
	endtask
	task wr(input logic [11:0] a, input logic [31:0] d, input logic [1:0] r);
		integer n;
		logic ha, hw, hb;
		bq.push_back(r);
		@(posedge core_clk);
		awaddr <= a;
		wdata <= d;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		hb = 1'b0;
		for (n = 0; n < 50 && !hb; n = n + 1) begin
			@(negedge core_clk);
			ha = awvalid && awready;
			hw = wvalid && wready;
			hb = bready && bvalid;
			@(posedge core_clk);
			if (ha) awvalid <= 1'b0;
			if (hw) wvalid <= 1'b0;
			if (hb) bready <= 1'b0;
		end
		if (!hb) hang;
	endtask
	task rd(input logic [11:0] a, input logic [33:0] e);
		integer n;
		logic ha, hr;
		rq.push_back(e);
		@(posedge core_clk);
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		hr = 1'b0;
		for (n = 0; n < 50 && !hr; n = n + 1) begin
			@(negedge core_clk);
			ha = arvalid && arready;
			hr = rready && rvalid;
			@(posedge core_clk);
			if (ha) arvalid <= 1'b0;
			if (hr) rready <= 1'b0;
		end
		if (!hr) hang;
	endtask
	task drain;
		integer n;
		for (n = 0; n < 90000 && lq.size() > 0; n = n + 1)
			@(negedge core_clk);
		if (lq.size() > 0) hang;
	endtask
	task next_fs;
		integer n;
		@(negedge core_clk);
		for (n = 0; n < 20000 && !tx_fs; n = n + 1)
			@(negedge core_clk);
		if (!tx_fs) hang;
	endtask
	task clk_case(input logic [31:0] c, input logic e, input logic r, input logic x);
		ext_on <= e;
		rcv_on <= r;
		wr(12'h000, c, 2'b00);
		repeat (150) @(negedge core_clk);
		chk("clock detect", {33'h0, x}, {33'h0, clk_det});
	endtask
	// expected bits of one frame; -1 marks a parity bit left unchecked
	task push_frame(input logic cb, input logic xb, input logic fe, input logic pdc,
		input logic pay);
		integer b, r, c, v;
		for (b = 0; b < 4760; b = b + 1) begin
			r = b / 680;
			c = (b / 85) % 8;
			if (b % 85 != 0) v = pay;
			else if (c == 0 && r < 2) v = xb;
			else if (c == 0 && r < 4) v = pdc ? -1 : 0;
			else if (c == 0) v = (r == 5);
			else if (c == 1 || c == 7) v = 1;
			else if (c == 3 || c == 5) v = 0;
			else if (!cb) v = 0;
			else if (r == 0 && c == 6) v = fe;
			else if (r == 2) v = pdc ? -1 : 0;
			else v = 1;
			lq.push_back(v);
		end
	endtask
	always @(negedge core_clk) begin
		if (bvalid && bready)
			chk("write response", {32'h0, bq.pop_front()}, {32'h0, bresp});
		if (rvalid && rready)
			chk("read data", rq.pop_front(), {rresp, rdata});
		if (tx_stb && lq.size() > 0) begin
			w = lq.pop_front();
			if (w >= 0)
				chk("line bit", {33'h0, w[0]}, {33'h0, tx_data});
		end
	end
	initial begin
		code[1] = 6'b011001;
		code[2] = 6'b001110;
		code[3] = 6'b000000;
		code[4] = 6'b010110;
		code[5] = 6'b011010;
		code[6] = 6'b001111;
		code[7] = 6'b011101;
		code[8] = 6'b010101;
		code[9] = 6'b011110;
		code[10] = 6'b000101;
		code[11] = 6'b000101;
		code[12] = 6'b000111;
		code[13] = 6'b011100;
		repeat (10) @(posedge core_clk);
		rst <= 1'b0;
		rd(12'h000, 34'h000000002);
		rd(12'h004, 34'h0001F0173);
		rd(12'h0FC, 34'h200000000);
		wr(12'h0FC, 32'h00000001, 2'b10);
		uw = $random(seed);
		uc = $random(seed);
		code[14] = uc;
		wr(12'h008, uw, 2'b00);
		rd(12'h008, {2'b00, uw});
		wr(12'h014, 32'h7FFFFFFF, 2'b00);
		// inverted user word, framing off
		wr(12'h004, 32'h001F0171, 2'b00);
		for (f = 0; f < 256; f = f + 1)
			lq.push_back(!uw[31 - f % 32]);
		wr(12'h000, 32'h00000009, 2'b00);
		drain;
		wr(12'h000, 32'h00000000, 2'b00);
		clk_case(32'h00000040, 1'b0, 1'b0, 1'b0);
		clk_case(32'h00000043, 1'b1, 1'b0, 1'b1);
		clk_case(32'h00000080, 1'b1, 1'b0, 1'b0);
		clk_case(32'h00000080, 1'b0, 1'b1, 1'b1);
		clk_case(32'h00000000, 1'b0, 1'b0, 1'b1);
		// one code select per frame over a full alarm word
		wr(12'h004, 32'h001F0177, 2'b00);
		wr(12'h00C, 32'h00000000, 2'b00);
		for (f = 0; f < 16; f = f + 1) begin
			wd = (f == 0 || f == 15) ? 16'hFFFF : {1'b0, code[f], 1'b0, 8'hFF};
			push_frame(1'b1, 1'b0, wd[15 - f], f == 0, 1'b1);
		end
		wr(12'h000, 32'h00000027, 2'b00);
		next_fs;
		for (f = 1; f < 16; f = f + 1) begin
			next_fs;
			wr(12'h00C, {18'h0, uc, 4'h0, f[3:0]}, 2'b00);
		end
		drain;
		wr(12'h000, 32'h00000000, 2'b00);
		// plain frame, code selected but not sent
		wr(12'h004, 32'h001F0176, 2'b00);
		wr(12'h00C, 32'h00000002, 2'b00);
		push_frame(1'b0, 1'b1, 1'b0, 1'b1, 1'b0);
		wr(12'h000, 32'h00000003, 2'b00);
		drain;
		wr(12'h000, 32'h00000010, 2'b00);
		rd(12'h000, 34'h000000008);
		rd(12'h004, 34'h0001F0173);
		// mid-run reset, then a 64-bit user pattern held in the memory page
		rst <= 1'b1;
		repeat (10) @(posedge core_clk);
		rst <= 1'b0;
		rd(12'h010, 34'h000000001);
		uw = $random(seed);
		wr(12'h800, uw, 2'b00);
		wr(12'h804, ~uw, 2'b00);
		wr(12'h004, 32'h003F0172, 2'b00);
		for (f = 0; f < 128; f = f + 1)
			lq.push_back(uw[31 - f % 32] ^ (f % 64 >= 32));
		wr(12'h000, 32'h00000001, 2'b00);
		drain;
		end_of_test;
	end
endmodule // tb
`default_nettype wire
